//--- shared/qcl_consts.vh
// constants for the quadrature counter with phase-locked latch trigger
`ifndef QCL_CONSTS_VH
`define QCL_CONSTS_VH

// ============================================================
// register byte offsets
`define QCL_ADR_CTRL        6'h00
`define QCL_ADR_COUNT       6'h04
`define QCL_ADR_RAW         6'h08
`define QCL_ADR_HELD        6'h0C
`define QCL_ADR_LATCH_SEL   6'h10
`define QCL_ADR_TRIG0       6'h14
`define QCL_ADR_TRIG1       6'h18
`define QCL_ADR_TRIG2       6'h1C
`define QCL_ADR_TRIG3       6'h20
`define QCL_ADR_BASE_PER    6'h24
`define QCL_ADR_PHASE_DEV   6'h28
`define QCL_ADR_TIME_CONST  6'h2C
`define QCL_ADR_PLIMIT      6'h30
`define QCL_ADR_PRESCALE    6'h34
`define QCL_ADR_HOST_READ   6'h38
`define QCL_ADR_HOST_WRITE  6'h3C

// ============================================================
// control register fields
`define QCL_CTL_RESET       0
`define QCL_CTL_ARM         1
`define QCL_CTL_RISE        2
`define QCL_CTL_GATE_EN     3
`define QCL_CTL_GATE_LOW    4
`define QCL_CTL_STEPDIR     5
`define QCL_CTL_FILTER      6
`define QCL_CTL_W           7
`define QCL_CTL_RST_VAL     7'h40

// ============================================================
// reset values
`define QCL_LATCH_SEL_RST   32'hFFFFFFFF
`define QCL_TRIG_RST        32'hFFFFFF9C
`define QCL_BASE_PER_RST    32'h000003E8
`define QCL_TIME_CONST_RST  32'h000007D0
`define QCL_PLIMIT_RST      32'h00400000
`define QCL_PRESCALE_RST    32'h00000001

// ============================================================
// timing
`define QCL_CLK_HZ          25000000
`define QCL_US_PER_SEC      1000000
`define QCL_CYC_PER_US      (`QCL_CLK_HZ / `QCL_US_PER_SEC)
`define QCL_FILT_LONG       15
`define QCL_FILT_SHORT      3

`endif

//--- hw/qcl_counter.v
// quadrature counter with marker zeroing and phase-locked count latch
`include "qcl_consts.vh"

module qcl_counter (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [5:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    // encoder inputs
    input  wire        phase_a_i,
    input  wire        phase_b_i,
    input  wire        marker_i,
    input  wire        marker_gate_i,
    // trigger outputs
    output wire [3:0]  trig_o
);

    // ============================================================
    // functions
    function [31:0] merge_bytes;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  sel;
        integer      k;
        begin
            merge_bytes = old_v;
            for (k = 0; k < 4; k = k + 1) begin
                if (sel[k]) begin
                    merge_bytes[k*8 +: 8] = new_v[k*8 +: 8];
                end
            end
        end
    endfunction

    // index of highest set bit, used as the loop filter shift
    function [4:0] msb_pos;
        input [31:0] v;
        integer      k;
        begin
            msb_pos = 5'h00;
            for (k = 0; k < 32; k = k + 1) begin
                if (v[k]) begin
                    msb_pos = k[4:0];
                end
            end
        end
    endfunction

    // fire point within the loop period; negative offsets count back from the read
    function [31:0] trig_target;
        input [31:0] ofs;
        input [31:0] per;
        begin
            trig_target = ofs[31] ? per + ofs : ofs;
        end
    endfunction

    // ============================================================
    // registers
    reg  [`QCL_CTL_W-1:0] ctrl_r;
    reg  [31:0]           count_r;
    reg  [31:0]           raw_r;
    reg  [31:0]           held_r;
    reg  [31:0]           latch_sel_r;
    reg  [31:0]           trig_ofs_r [0:3];
    reg  [31:0]           base_per_r;
    reg  [31:0]           phase_dev_r;
    reg  [31:0]           time_const_r;
    reg  [31:0]           plimit_r;
    reg  [31:0]           prescale_r;
    reg  [31:0]           rdata_r;
    reg                   ack_r;

    wire        bus_req   = wb_cyc_i & wb_stb_i & ~ack_r;
    wire        bus_wr    = bus_req & wb_we_i;
    wire        host_rd   = bus_wr & (wb_adr_i == `QCL_ADR_HOST_READ);
    wire        host_wr   = bus_wr & (wb_adr_i == `QCL_ADR_HOST_WRITE);

    // ============================================================
    // input filters
    reg  [2:0]  filt_r;
    reg  [3:0]  filt_cnt_r [0:2];
    wire [2:0]  raw_in  = {marker_i, phase_b_i, phase_a_i};
    localparam integer FILT_LONG_M1  = `QCL_FILT_LONG - 1;
    localparam integer FILT_SHORT_M1 = `QCL_FILT_SHORT - 1;
    wire [3:0]  filt_lim = ctrl_r[`QCL_CTL_FILTER] ? FILT_LONG_M1[3:0]
                                                    : FILT_SHORT_M1[3:0];
    integer     fi;

    // the gate input is a level qualifier only, so it is not filtered
    always @(posedge clk_i) begin
        if (rst_i) begin
            filt_r <= 3'h0;
            for (fi = 0; fi < 3; fi = fi + 1) begin
                filt_cnt_r[fi] <= 4'h0;
            end
        end else begin
            for (fi = 0; fi < 3; fi = fi + 1) begin
                if (raw_in[fi] == filt_r[fi]) begin
                    filt_cnt_r[fi] <= 4'h0;
                end else if (filt_cnt_r[fi] >= filt_lim) begin
                    filt_r[fi]     <= raw_in[fi];
                    filt_cnt_r[fi] <= 4'h0;
                end else begin
                    filt_cnt_r[fi] <= filt_cnt_r[fi] + 4'h1;
                end
            end
        end
    end

    // ============================================================
    // decode
    reg  [2:0]  prev_r;
    wire        a_new = filt_r[0];
    wire        b_new = filt_r[1];
    wire        a_old = prev_r[0];
    wire        b_old = prev_r[1];
    reg         step_up;
    reg         step_dn;

    always @* begin
        step_up = 1'b0;
        step_dn = 1'b0;
        if (ctrl_r[`QCL_CTL_STEPDIR]) begin
            // step on rising A, B high means count down
            if (a_new & ~a_old) begin
                step_up = ~b_new;
                step_dn = b_new;
            end
        end else if ((a_new ^ a_old) ^ (b_new ^ b_old)) begin
            // both lines moving at once is an illegal jump and is dropped
            step_up = a_new ^ b_old;
            step_dn = a_old ^ b_new;
        end
    end

    wire mk_new   = filt_r[2];
    wire mk_old   = prev_r[2];
    wire mk_edge  = ctrl_r[`QCL_CTL_RISE] ? (mk_new & ~mk_old)
                                          : (~mk_new & mk_old);
    wire gate_ok  = ctrl_r[`QCL_CTL_GATE_LOW] ? ~marker_gate_i
                                              : marker_gate_i;
    wire mk_event = mk_edge & (~ctrl_r[`QCL_CTL_GATE_EN] | gate_ok);
    wire mk_zero  = mk_event & ctrl_r[`QCL_CTL_ARM];
    wire [31:0] delta = step_up ? 32'h00000001 : (step_dn ? 32'hFFFFFFFF : 32'h00000000);

    always @(posedge clk_i) begin
        if (rst_i) begin
            prev_r  <= 3'h0;
            count_r <= 32'h00000000;
            raw_r   <= 32'h00000000;
        end else begin
            prev_r <= filt_r;
            raw_r  <= raw_r + delta;
            if (ctrl_r[`QCL_CTL_RESET]) begin
                count_r <= 32'h00000000;
            end else if (mk_zero) begin
                count_r <= 32'h00000000;
            end else begin
                count_r <= count_r + delta;
            end
        end
    end

    // ============================================================
    // phase-locked trigger unit
    reg  [4:0]  us_div_r;
    reg  [31:0] pre_cnt_r;
    reg  [31:0] phase_r;
    reg  [31:0] period_r;
    localparam integer US_LAST = `QCL_CYC_PER_US - 1;
    wire        us_tick  = (us_div_r == US_LAST[4:0]);
    wire        loop_tick = us_tick & (pre_cnt_r + 32'h1 >= prescale_r);
    // deviation wraps into the half period nearest zero
    wire [31:0] half_per = {1'b0, period_r[31:1]};
    wire [31:0] dev_raw  = (phase_r >= half_per) ? phase_r - period_r : phase_r;
    wire [31:0] lim_neg  = 32'h0 - plimit_r;
    wire [31:0] dev_clip = ($signed(dev_raw) > $signed(plimit_r)) ? plimit_r :
                           ($signed(dev_raw) < $signed(lim_neg)) ? lim_neg : dev_raw;
    wire [31:0] dev_step = $signed(dev_clip) >>> msb_pos(time_const_r);
    wire [31:0] dev_pull = (dev_step == 32'h0 && dev_clip != 32'h0) ?
                           (dev_clip[31] ? 32'hFFFFFFFF : 32'h00000001) : dev_step;
    wire        locking  = host_rd & (plimit_r != 32'h0);

    always @(posedge clk_i) begin
        if (rst_i) begin
            us_div_r    <= 5'h00;
            pre_cnt_r   <= 32'h00000000;
            phase_r     <= 32'h00000000;
            period_r    <= `QCL_BASE_PER_RST;
            phase_dev_r <= 32'h00000000;
        end else begin
            us_div_r <= us_tick ? 5'h00 : us_div_r + 5'h01;
            if (us_tick) begin
                pre_cnt_r <= loop_tick ? 32'h0 : pre_cnt_r + 32'h1;
            end
            if (host_rd) begin
                phase_dev_r <= dev_raw;
            end
            if (locking) begin
                // pull phase toward the read instant, nudge period by one
                phase_r <= phase_r - dev_pull;
                if (dev_raw[31] && period_r > 32'h2) begin
                    period_r <= period_r - 32'h1;
                end else if (!dev_raw[31] && dev_raw != 32'h0) begin
                    period_r <= period_r + 32'h1;
                end
            end else if (plimit_r == 32'h0) begin
                period_r <= base_per_r;
                if (loop_tick) begin
                    phase_r <= (phase_r + 32'h1 >= base_per_r) ? 32'h0 : phase_r + 32'h1;
                end
            end else if (loop_tick) begin
                phase_r <= (phase_r + 32'h1 >= period_r) ? 32'h0 : phase_r + 32'h1;
            end
            // a new base period takes effect at once, not only when free-running
            if (bus_wr && (wb_adr_i == `QCL_ADR_BASE_PER)) begin
                period_r <= merge_bytes(base_per_r, wb_dat_i, wb_sel_i);
            end
        end
    end

    // ============================================================
    // trigger timers
    reg  [3:0]  trig_r;
    integer     ti;

    always @(posedge clk_i) begin
        if (rst_i) begin
            trig_r <= 4'h0;
        end else begin
            for (ti = 0; ti < 4; ti = ti + 1) begin
                // negative offset fires that many loop ticks (prescale_r microseconds each) before the read
                trig_r[ti] <= loop_tick &
                              (phase_r == trig_target(trig_ofs_r[ti], period_r));
            end
        end
    end

    assign trig_o = trig_r;

    // ============================================================
    // count latch
    reg         latch_now;

    always @* begin
        case (latch_sel_r)
            32'h00000000: latch_now = host_wr;
            32'h00000001: latch_now = trig_r[0];
            32'h00000002: latch_now = trig_r[1];
            32'h00000003: latch_now = trig_r[2];
            32'h00000004: latch_now = trig_r[3];
            default:      latch_now = 1'b0;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            held_r <= 32'h00000000;
        end else if (latch_now) begin
            held_r <= count_r;
        end
    end

    // ============================================================
    // wishbone register file
    wire [31:0] ctrl_w = merge_bytes({{(32-`QCL_CTL_W){1'b0}}, ctrl_r}, wb_dat_i, wb_sel_i);
    integer     ri;

    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r       <= `QCL_CTL_RST_VAL;
            latch_sel_r  <= `QCL_LATCH_SEL_RST;
            base_per_r   <= `QCL_BASE_PER_RST;
            time_const_r <= `QCL_TIME_CONST_RST;
            plimit_r     <= `QCL_PLIMIT_RST;
            prescale_r   <= `QCL_PRESCALE_RST;
            for (ri = 0; ri < 4; ri = ri + 1) begin
                trig_ofs_r[ri] <= `QCL_TRIG_RST;
            end
        end else begin
            // marker clears the arm flag; a software write in the same cycle wins
            if (mk_zero) begin
                ctrl_r[`QCL_CTL_ARM] <= 1'b0;
            end
            if (bus_wr) begin
                case (wb_adr_i)
                    `QCL_ADR_CTRL:       ctrl_r       <= ctrl_w[`QCL_CTL_W-1:0];
                    `QCL_ADR_LATCH_SEL:  latch_sel_r  <= merge_bytes(latch_sel_r, wb_dat_i,
                                                                     wb_sel_i);
                    `QCL_ADR_TRIG0:      trig_ofs_r[0] <= merge_bytes(trig_ofs_r[0], wb_dat_i,
                                                                      wb_sel_i);
                    `QCL_ADR_TRIG1:      trig_ofs_r[1] <= merge_bytes(trig_ofs_r[1], wb_dat_i,
                                                                      wb_sel_i);
                    `QCL_ADR_TRIG2:      trig_ofs_r[2] <= merge_bytes(trig_ofs_r[2], wb_dat_i,
                                                                      wb_sel_i);
                    `QCL_ADR_TRIG3:      trig_ofs_r[3] <= merge_bytes(trig_ofs_r[3], wb_dat_i,
                                                                      wb_sel_i);
                    `QCL_ADR_BASE_PER:   base_per_r   <= merge_bytes(base_per_r, wb_dat_i,
                                                                     wb_sel_i);
                    `QCL_ADR_TIME_CONST: time_const_r <= merge_bytes(time_const_r, wb_dat_i,
                                                                     wb_sel_i);
                    `QCL_ADR_PLIMIT:     plimit_r     <= merge_bytes(plimit_r, wb_dat_i,
                                                                     wb_sel_i);
                    `QCL_ADR_PRESCALE:   prescale_r   <= merge_bytes(prescale_r, wb_dat_i,
                                                                     wb_sel_i);
                    default:             ;
                endcase
            end
        end
    end

    // one wait state: ack one cycle after the request, dropped the next cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h00000000;
        end else begin
            ack_r <= bus_req;
            if (bus_req & ~wb_we_i) begin
                case (wb_adr_i)
                    `QCL_ADR_CTRL:       rdata_r <= {{(32-`QCL_CTL_W){1'b0}}, ctrl_r};
                    `QCL_ADR_COUNT:      rdata_r <= count_r;
                    `QCL_ADR_RAW:        rdata_r <= raw_r;
                    `QCL_ADR_HELD:       rdata_r <= held_r;
                    `QCL_ADR_LATCH_SEL:  rdata_r <= latch_sel_r;
                    `QCL_ADR_TRIG0:      rdata_r <= trig_ofs_r[0];
                    `QCL_ADR_TRIG1:      rdata_r <= trig_ofs_r[1];
                    `QCL_ADR_TRIG2:      rdata_r <= trig_ofs_r[2];
                    `QCL_ADR_TRIG3:      rdata_r <= trig_ofs_r[3];
                    `QCL_ADR_BASE_PER:   rdata_r <= base_per_r;
                    `QCL_ADR_PHASE_DEV:  rdata_r <= phase_dev_r;
                    `QCL_ADR_TIME_CONST: rdata_r <= time_const_r;
                    `QCL_ADR_PLIMIT:     rdata_r <= plimit_r;
                    `QCL_ADR_PRESCALE:   rdata_r <= prescale_r;
                    default:             rdata_r <= 32'h00000000;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

endmodule // qcl_counter

//--- verification/qcl_counter_checker.sv
// concurrent checks on the counter's bus, trigger and count ports
// ============================================================
// checker
module qcl_counter_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [5:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        phase_a_i,
    input wire logic        phase_b_i,
    input wire logic        marker_i,
    input wire logic        marker_gate_i,
    input wire logic [3:0]  trig_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // shadow of the count-reset bit and of writes to the loop settings
    logic ctl_rst_r;
    logic cfg_wr_r;
    wire  req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire  rd_req = req && !wb_we_i;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_rst_r <= 1'b0;
            cfg_wr_r  <= 1'b0;
        end else if (req && wb_we_i) begin
            if (wb_adr_i == 6'h00 && wb_sel_i[0]) ctl_rst_r <= wb_dat_i[0];
            if (wb_adr_i >= 6'h2C && wb_adr_i <= 6'h37) cfg_wr_r <= 1'b1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_ack_answer; req |=> wb_ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not acked");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_trig_pulse; (trig_o != 4'h0) |=> (trig_o == 4'h0); endproperty
    a_trig_pulse: assert property (p_trig_pulse) else $error("trigger not a pulse");
    property p_quiet; $fell(rst_i) |-> !wb_ack_o && trig_o == 4'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("outputs busy after reset");
    property p_cnt_held; rd_req && wb_adr_i == 6'h04 && ctl_rst_r |=> wb_dat_o == 32'h0;
    endproperty
    a_cnt_held: assert property (p_cnt_held) else $error("count not held at zero");
    property p_tc_dflt; rd_req && wb_adr_i == 6'h2C && !cfg_wr_r |=> wb_dat_o == 32'h7D0;
    endproperty
    a_tc_dflt: assert property (p_tc_dflt) else $error("time constant default");
    property p_plim_dflt;
        rd_req && wb_adr_i == 6'h30 && !cfg_wr_r |=> wb_dat_o == 32'h00400000;
    endproperty
    a_plim_dflt: assert property (p_plim_dflt) else $error("phase limit default");
    property p_pre_dflt; rd_req && wb_adr_i == 6'h34 && !cfg_wr_r |=> wb_dat_o == 32'h1;
    endproperty
    a_pre_dflt: assert property (p_pre_dflt) else $error("prescale default");
endmodule // qcl_counter_checker

bind qcl_counter qcl_counter_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .phase_a_i(phase_a_i), .phase_b_i(phase_b_i), .marker_i(marker_i),
    .marker_gate_i(marker_gate_i), .trig_o(trig_o));

//--- verification/qcl_enc_model.sv
// incremental encoder stand-in: phases, marker and marker gate
// ============================================================
// model
module qcl_enc_model (
    input  wire logic clk_i,
    output logic      phase_a_o = 1'b0,
    output logic      phase_b_o = 1'b0,
    output logic      marker_o = 1'b0,
    output logic      gate_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = 20; // longer than the 15-sample filter so every level counts
    int pos = 0;
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // gray sequence 00,10,11,01 counts up; reversed counts down
    task automatic quad(input int n);
        repeat (n < 0 ? -n : n) begin
            pos = (n < 0) ? pos - 1 : pos + 1;
            phase_a_o <= (pos & 3) inside {1, 2};
            phase_b_o <= (pos & 3) inside {2, 3};
            hold(HOLD);
        end
    endtask
    // direction settles before the first step
    task automatic step(input int n);
        phase_b_o <= (n < 0);
        hold(HOLD);
        repeat (n < 0 ? -n : n) begin
            phase_a_o <= 1'b1;
            hold(HOLD);
            phase_a_o <= 1'b0;
            hold(HOLD);
        end
    endtask
    task automatic pulse(input int len);
        phase_a_o <= 1'b1;
        hold(len);
        phase_a_o <= 1'b0;
        hold(HOLD);
    endtask
    task automatic level(input logic m, input logic g);
        marker_o <= m;
        gate_o   <= g;
        hold(HOLD);
    endtask
endmodule // qcl_enc_model

//--- verification/qcl_counter_bench.sv
// self-checking bench for the quadrature counter
// ============================================================
// bench
module qcl_counter_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 0;
    logic        rst_i = 1;
    logic        wb_cyc_i = 0;
    logic        wb_stb_i = 0;
    logic        wb_we_i = 0;
    logic [5:0]  wb_adr_i = 6'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o;
    wire  [3:0]  trig_o;
    wire         pa, pb, mk, gt;
    int          mismatches = 0, n_tests = 0, seed = 43, cnt = 0, raw = 0, n, k;
    logic [31:0] exp_q[$];
    logic [31:0] rv;
    logic [31:0] ctl[7] = '{32'h46, 32'h42, 32'h4E, 32'h4E, 32'h5E, 32'h5E, 32'h44};
    logic        gl[7] = '{0, 0, 0, 1, 1, 0, 0}; // gate level per case
    logic        hit[7] = '{1, 1, 0, 1, 0, 1, 0};
    always #20 clk_i = ~clk_i;
    qcl_counter i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phase_a_i(pa), .phase_b_i(pb),
        .marker_i(mk), .marker_gate_i(gt), .trig_o(trig_o));
    qcl_enc_model i_enc (.clk_i(clk_i), .phase_a_o(pa), .phase_b_o(pb), .marker_o(mk),
        .gate_o(gt));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // ============================================================
    // bus cycles: hold the request until ack is sampled
    task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] s);
        int t = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin @(posedge clk_i); t++; end while (!wb_ack_o && t < 50);
        if (!wb_ack_o) check(32'h0, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, 4'hF);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h0, 4'hF);
    endtask
    // read data is judged against the oldest note
    always @(posedge clk_i) begin
        if (wb_ack_o && !wb_we_i && exp_q.size() > 0) check(wb_dat_o, exp_q.pop_front());
    end
    // cycles between two fires of the first timer
    task automatic gap_meas(input int e);
        int t = 0;
        int c = 0;
        while (!trig_o[0] && t < 3000) begin @(posedge clk_i); t++; end
        @(posedge clk_i);
        while (!trig_o[0] && c < 3000) begin @(posedge clk_i); c++; end
        check(32'(c + 1), 32'(e));
    endtask
    task automatic final_report;
        if (mismatches == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        mismatches++;
        $display("ERROR %0t: watchdog expired", $time);
        final_report;
    end
    // ============================================================
    // main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(6'h00, 32'h40);
        rd(6'h10, 32'hFFFFFFFF);
        for (k = 0; k < 4; k++) rd(6'h14 + 6'(4 * k), 32'hFFFFFF9C);
        rd(6'h24, 32'h3E8);
        rd(6'h2C, 32'h7D0);
        rd(6'h30, 32'h00400000);
        rd(6'h34, 32'h1);
        // only the two low byte lanes of a random word may land
        rv = $random(seed);
        bus(6'h18, 1'b1, rv, 4'h3);
        rd(6'h18, {16'hFFFF, rv[15:0]});
        repeat (4) begin
            n = $random(seed) % 9;
            i_enc.quad(n);
            cnt += n;
            raw += n;
            rd(6'h04, cnt);
        end
        rd(6'h0C, 32'h0);
        wr(6'h04, 32'h12345678);
        rd(6'h04, cnt);
        wr(6'h00, 32'h41);
        i_enc.quad(3);
        raw += 3;
        rd(6'h04, 32'h0);
        rd(6'h08, raw);
        wr(6'h00, 32'h40);
        cnt = 0;
        wr(6'h10, 32'h0);
        i_enc.quad(-2);
        wr(6'h3C, 32'h0);
        i_enc.quad(1);
        cnt -= 1;
        raw -= 1;
        rd(6'h0C, cnt - 1);
        for (k = 0; k < 7; k++) begin
            i_enc.level(1'b0, gl[k]);
            wr(6'h00, ctl[k]);
            i_enc.quad(1);
            cnt++;
            raw++;
            i_enc.level(1'b1, gl[k]);
            if (hit[k] && ctl[k][2]) cnt = 0;
            rd(6'h04, cnt);
            i_enc.level(1'b0, gl[k]);
            if (hit[k]) cnt = 0;
            rd(6'h04, cnt);
            rd(6'h00, hit[k] ? (ctl[k] & ~32'h2) : ctl[k]);
        end
        n = i_enc.pos & 3;
        i_enc.quad(-n);
        cnt -= n;
        raw -= n;
        wr(6'h00, 32'h60);
        i_enc.step(3);
        i_enc.step(-2);
        i_enc.step(0);
        cnt++;
        raw++;
        rd(6'h04, cnt);
        i_enc.pulse(10);
        rd(6'h04, cnt);
        wr(6'h00, 32'h20);
        i_enc.pulse(10);
        i_enc.pulse(2);
        cnt++;
        raw++;
        rd(6'h04, cnt);
        rd(6'h08, raw);
        // a short loop period keeps the trigger checks brief
        wr(6'h24, 32'd20);
        wr(6'h14, 32'hFFFFFFFB);
        wr(6'h10, 32'h1);
        i_enc.pulse(20);
        cnt++;
        gap_meas(500);
        rd(6'h0C, cnt);
        wr(6'h34, 32'h2);
        gap_meas(1000);
        // a host read two cycles after the fire sees phase 16 of 20, i.e. four early
        wr(6'h38, 32'h0);
        rd(6'h28, 32'hFFFFFFFC);
        final_report;
    end
endmodule // qcl_counter_bench
